// file: pkg/rsk_pkg.sv
package rsk_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    // Register byte offsets
    localparam logic [11:0] OFF_CMD    = 12'h000;
    localparam logic [11:0] OFF_ACC    = 12'h004;
    localparam logic [11:0] OFF_MEM    = 12'h008;
    localparam logic [11:0] OFF_IMM    = 12'h00c;
    localparam logic [11:0] OFF_FLAGS  = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;

    // Command word fields
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_OP_W    = 5;
    localparam int unsigned CMD_BIT_LSB = 8;
    localparam int unsigned CMD_BIT_W   = 3;
    localparam int unsigned CMD_GO_BIT  = 31;

    // Status word fields
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_SKIP_BIT = 1;
    localparam int unsigned ST_ERR_BIT  = 2;
    localparam int unsigned ST_CNT_LSB  = 8;
    localparam int unsigned ST_CNT_W    = 8;

    // Reset values and byte constants
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam logic [7:0] IMM_RST = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    typedef enum logic [4:0] {
        OP_NONE               = 5'h00,
        OP_ROT_LEFT_C_MEM     = 5'h01,
        OP_ROT_LEFT_C_ACC     = 5'h02,
        OP_ROT_RIGHT_MEM      = 5'h03,
        OP_ROT_RIGHT_ACC      = 5'h04,
        OP_ROT_RIGHT_C_MEM    = 5'h05,
        OP_ROT_RIGHT_C_ACC    = 5'h06,
        OP_SUB_BORROW_ACC     = 5'h07,
        OP_SUB_BORROW_MEM     = 5'h08,
        OP_DEC_SKIP_MEM       = 5'h09,
        OP_DEC_SKIP_ACC       = 5'h0a,
        OP_FILL_ONES_MEM      = 5'h0b,
        OP_FILL_BIT_MEM       = 5'h0c,
        OP_INC_SKIP_MEM       = 5'h0d,
        OP_INC_SKIP_ACC       = 5'h0e,
        OP_SKIP_BIT_NZ        = 5'h0f,
        OP_MINUS_MEM_ACC      = 5'h10,
        OP_MINUS_MEM_MEM      = 5'h11,
        OP_MINUS_IMM_ACC      = 5'h12,
        OP_NIBBLE_SWAP_MEM    = 5'h13
    } rsk_op_t;

    localparam logic [4:0] OP_LAST = 5'h13;

    typedef struct packed {
        logic signed_range_flag;
        logic zero_flag;
        logic half_wrap_flag;
        logic carry_flag;
    } rsk_flags_t;

    localparam rsk_flags_t FLAGS_RST = 4'h0;

    typedef struct packed {
        rsk_op_t    op;
        logic [2:0] bit_sel;
    } rsk_cmd_t;

    typedef struct packed {
        logic [7:0] res;
        rsk_flags_t flags;
    } rsk_arith_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_DUMMY = 3'b100
    } rsk_state_t;

endpackage

// file: hdl/rsk_adder.sv
`timescale 1ns/1ps
module rsk_adder (
    // Operands
    input  wire logic [7:0]         a,
    input  wire logic [7:0]         b,
    input  wire logic               cin,
    // Sum and flags of a plus inverted b plus carry in
    output rsk_pkg::rsk_arith_t     sum
);
    logic [7:0] b_inv;
    logic [4:0] lo;
    logic [4:0] hi;
    logic [7:0] res;

    assign b_inv = ~b;
    assign lo    = {1'b0, a[3:0]} + {1'b0, b_inv[3:0]} + {4'h0, cin};
    assign hi    = {1'b0, a[7:4]} + {1'b0, b_inv[7:4]} + {4'h0, lo[4]};
    assign res   = {hi[3:0], lo[3:0]};

    assign sum.res                     = res;
    assign sum.flags.carry_flag        = hi[4];
    assign sum.flags.half_wrap_flag    = lo[4];
    assign sum.flags.zero_flag         = (res == rsk_pkg::BYTE_ZERO);
    assign sum.flags.signed_range_flag = (a[7] == b_inv[7]) && (res[7] != a[7]);
endmodule

// file: hdl/rsk_bitops.sv
`timescale 1ns/1ps
module rsk_bitops (
    // Operation and operands
    input  wire rsk_pkg::rsk_op_t   op,
    input  wire logic [7:0]         mem,
    input  wire logic               cin,
    input  wire logic [2:0]         bit_sel,
    // Results
    output logic [7:0]              res,
    output logic                    cout,
    output logic                    skip
);
    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        step = up ? (v + 8'h01) : (v - 8'h01);
    endfunction

    logic [7:0] inc_v;
    logic [7:0] dec_v;
    logic [7:0] bit_mask;

    assign inc_v    = step(mem, 1'b1);
    assign dec_v    = step(mem, 1'b0);
    assign bit_mask = 8'h01 << bit_sel;

    always_comb begin
        res  = mem;
        cout = cin;
        skip = 1'b0;
        unique case (op)
            rsk_pkg::OP_ROT_LEFT_C_MEM, rsk_pkg::OP_ROT_LEFT_C_ACC: begin
                res  = {mem[6:0], cin};
                cout = mem[7];
            end
            rsk_pkg::OP_ROT_RIGHT_MEM, rsk_pkg::OP_ROT_RIGHT_ACC: res = {mem[0], mem[7:1]};
            rsk_pkg::OP_ROT_RIGHT_C_MEM, rsk_pkg::OP_ROT_RIGHT_C_ACC: begin
                res  = {cin, mem[7:1]};
                cout = mem[0];
            end
            rsk_pkg::OP_DEC_SKIP_MEM, rsk_pkg::OP_DEC_SKIP_ACC: begin
                res  = dec_v;
                skip = (dec_v == rsk_pkg::BYTE_ZERO);
            end
            rsk_pkg::OP_INC_SKIP_MEM, rsk_pkg::OP_INC_SKIP_ACC: begin
                res  = inc_v;
                skip = (inc_v == rsk_pkg::BYTE_ZERO);
            end
            rsk_pkg::OP_FILL_ONES_MEM: res = rsk_pkg::ALL_ONES;
            rsk_pkg::OP_FILL_BIT_MEM: res = mem | bit_mask;
            rsk_pkg::OP_SKIP_BIT_NZ: skip = |(mem & bit_mask);
            rsk_pkg::OP_NIBBLE_SWAP_MEM: res = {mem[3:0], mem[7:4]};
            default: res = mem;
        endcase
    end
endmodule

// file: hdl/rsk_datapath.sv
// Functional notes
// RULE_01 - Memory rotate left through carry: carry to bit 0, bit 7 to carry.
// RULE_02 - Same left rotate through carry, result to accumulator, memory kept.
// RULE_03 - Memory rotate right, bit 0 to bit 7, back to memory, no flags.
// RULE_04 - Right rotate of memory into accumulator, memory and flags kept.
// RULE_05 - Memory rotate right through carry: carry to bit 7, bit 0 to carry.
// RULE_06 - Right rotate through carry into accumulator, memory kept.
// RULE_07 - Acc plus inverted memory plus carry into acc, four flags updated.
// RULE_08 - Acc plus inverted memory plus carry into memory, four flags updated.
// RULE_09 - Memory minus one back to memory; zero result skips next, 2 cycles.
// RULE_10 - Memory minus one into accumulator; zero result skips next.
// RULE_11 - Whole-byte fill writes all ones to memory, flags kept.
// RULE_12 - Single-bit fill sets only the selected memory bit, flags kept.
// RULE_13 - Memory plus one back to memory; zero result skips next, 2 cycles.
// RULE_14 - Memory plus one into accumulator; zero result skips next.
// RULE_15 - Selected memory bit set skips next with dummy cycle, nothing changes.
// RULE_16 - Acc plus inverted memory plus one into acc, four flags updated.
// RULE_17 - Acc plus inverted memory plus one into memory, four flags updated.
// RULE_18 - Acc plus inverted immediate plus one into acc, four flags updated.
// RULE_19 - Memory nibbles exchanged and written back, flags kept.
// RULE_20 - Flags not affected by an operation hold, also over skip cycles.
`timescale 1ns/1ps
module rsk_datapath (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [rsk_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [rsk_pkg::DATA_W-1:0]    pwdata,
    output logic [rsk_pkg::DATA_W-1:0]         prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Sequencer side
    output logic                               fetch_discard,
    output logic                               op_done
);
    // Bus handshake
    logic                         pready_reg;
    logic                         pslverr_reg;
    logic [rsk_pkg::DATA_W-1:0]   prdata_reg;
    logic                         access;
    logic                         first_access;
    logic                         fire;
    logic                         wr_fire;

    // Address decode
    logic                         hit_cmd;
    logic                         hit_acc;
    logic                         hit_mem;
    logic                         hit_imm;
    logic                         hit_flags;
    logic                         hit_status;
    logic                         mapped;

    // Architectural state
    logic [7:0]                   acc_reg;
    logic [7:0]                   acc_next;
    logic [7:0]                   mem_reg;
    logic [7:0]                   mem_next;
    logic [7:0]                   imm_reg;
    logic [7:0]                   imm_next;
    rsk_pkg::rsk_flags_t          flags_reg;
    rsk_pkg::rsk_flags_t          flags_next;
    rsk_pkg::rsk_cmd_t            cmd_reg;
    rsk_pkg::rsk_cmd_t            cmd_next;
    rsk_pkg::rsk_state_t          state_reg;
    rsk_pkg::rsk_state_t          state_next;
    logic                         skip_reg;
    logic                         skip_next;
    logic                         err_reg;
    logic                         err_next;
    logic [rsk_pkg::ST_CNT_W-1:0] cnt_reg;
    logic [rsk_pkg::ST_CNT_W-1:0] cnt_next;
    logic                         discard_reg;
    logic                         done_reg;

    // Command launch
    logic                         idle;
    logic                         exec;
    logic                         dummy;
    logic                         go;
    logic [4:0]                   wr_op;
    logic                         op_legal;
    logic                         launch;
    logic                         bad_launch;
    logic                         err_clear;

    // Register write strobes
    logic                         wr_acc;
    logic                         wr_mem;
    logic                         wr_imm;
    logic                         wr_flags;
    logic                         exec_acc;
    logic                         exec_mem;
    logic [7:0]                   wr_byte;
    rsk_pkg::rsk_flags_t          wr_flags_val;
    logic                         busy;

    // Operation classes
    rsk_pkg::rsk_op_t             op;
    logic                         is_arith;
    logic                         is_rot_carry;
    logic                         to_acc;
    logic                         to_mem;
    logic                         use_imm;
    logic                         use_borrow;

    // Units
    rsk_pkg::rsk_arith_t          arith;
    logic [7:0]                   adder_b;
    logic                         adder_cin;
    logic [7:0]                   bit_res;
    logic                         bit_cout;
    logic                         bit_skip;
    logic [7:0]                   result;
    logic                         skip_now;
    logic [rsk_pkg::DATA_W-1:0]   rd_data;

    // Bus write that lands in a register only while no operation runs
    function automatic logic idle_write(input logic strobe, input logic hit, input logic free);
        idle_write = strobe & hit & free;
    endfunction

    // Bus phases
    assign access       = psel & penable;
    assign first_access = access & ~pready_reg;
    assign fire         = access & pready_reg;
    assign wr_fire      = fire & pwrite;

    assign hit_cmd    = (paddr == rsk_pkg::OFF_CMD);
    assign hit_acc    = (paddr == rsk_pkg::OFF_ACC);
    assign hit_mem    = (paddr == rsk_pkg::OFF_MEM);
    assign hit_imm    = (paddr == rsk_pkg::OFF_IMM);
    assign hit_flags  = (paddr == rsk_pkg::OFF_FLAGS);
    assign hit_status = (paddr == rsk_pkg::OFF_STATUS);
    assign mapped     = hit_cmd | hit_acc | hit_mem | hit_imm | hit_flags | hit_status;

    // State decode
    assign idle  = (state_reg == rsk_pkg::ST_IDLE);
    assign exec  = (state_reg == rsk_pkg::ST_EXEC);
    assign dummy = (state_reg == rsk_pkg::ST_DUMMY);

    // Command write
    assign go         = pwdata[rsk_pkg::CMD_GO_BIT];
    assign wr_op      = pwdata[rsk_pkg::CMD_OP_LSB +: rsk_pkg::CMD_OP_W];
    assign op_legal   = (wr_op != rsk_pkg::OP_NONE) && (wr_op <= rsk_pkg::OP_LAST);
    assign launch     = wr_fire & hit_cmd & go & idle & op_legal;
    assign bad_launch = wr_fire & hit_cmd & go & idle & ~op_legal;
    assign err_clear  = wr_fire & hit_status & pwdata[rsk_pkg::ST_ERR_BIT];

    assign cmd_next.op      = launch ? rsk_pkg::rsk_op_t'(wr_op) : cmd_reg.op;
    assign cmd_next.bit_sel = launch ? pwdata[rsk_pkg::CMD_BIT_LSB +: rsk_pkg::CMD_BIT_W]
                                     : cmd_reg.bit_sel;

    // Operation classes
    assign op = cmd_reg.op;

    assign is_arith = op inside {rsk_pkg::OP_SUB_BORROW_ACC, rsk_pkg::OP_SUB_BORROW_MEM,
                                 rsk_pkg::OP_MINUS_MEM_ACC, rsk_pkg::OP_MINUS_MEM_MEM,
                                 rsk_pkg::OP_MINUS_IMM_ACC};

    assign is_rot_carry = op inside {rsk_pkg::OP_ROT_LEFT_C_MEM, rsk_pkg::OP_ROT_LEFT_C_ACC,
                                     rsk_pkg::OP_ROT_RIGHT_C_MEM,
                                     rsk_pkg::OP_ROT_RIGHT_C_ACC};

    assign to_acc = op inside {rsk_pkg::OP_ROT_LEFT_C_ACC, rsk_pkg::OP_ROT_RIGHT_ACC,
                               rsk_pkg::OP_ROT_RIGHT_C_ACC, rsk_pkg::OP_SUB_BORROW_ACC,
                               rsk_pkg::OP_DEC_SKIP_ACC, rsk_pkg::OP_INC_SKIP_ACC,
                               rsk_pkg::OP_MINUS_MEM_ACC, rsk_pkg::OP_MINUS_IMM_ACC};

    assign to_mem = op inside {rsk_pkg::OP_ROT_LEFT_C_MEM, rsk_pkg::OP_ROT_RIGHT_MEM,
                               rsk_pkg::OP_ROT_RIGHT_C_MEM, rsk_pkg::OP_SUB_BORROW_MEM,
                               rsk_pkg::OP_DEC_SKIP_MEM, rsk_pkg::OP_FILL_ONES_MEM,
                               rsk_pkg::OP_FILL_BIT_MEM, rsk_pkg::OP_INC_SKIP_MEM,
                               rsk_pkg::OP_MINUS_MEM_MEM, rsk_pkg::OP_NIBBLE_SWAP_MEM};

    assign use_imm    = (op == rsk_pkg::OP_MINUS_IMM_ACC); // RULE_18
    assign use_borrow = op inside {rsk_pkg::OP_SUB_BORROW_ACC, rsk_pkg::OP_SUB_BORROW_MEM};

    // Subtract operand and carry in
    assign adder_b   = use_imm ? imm_reg : mem_reg; // RULE_16 RULE_17 RULE_18
    assign adder_cin = use_borrow ? flags_reg.carry_flag : 1'b1; // RULE_07 RULE_08

    rsk_adder u_adder (
        .a   (acc_reg),
        .b   (adder_b),
        .cin (adder_cin),
        .sum (arith)
    );

    rsk_bitops u_bitops (
        .op      (op),
        .mem     (mem_reg),
        .cin     (flags_reg.carry_flag),
        .bit_sel (cmd_reg.bit_sel),
        .res     (bit_res),
        .cout    (bit_cout),
        .skip    (bit_skip)
    );

    // Result routing
    assign result   = is_arith ? arith.res : bit_res;
    assign skip_now = exec & ~is_arith & bit_skip; // RULE_09 RULE_10 RULE_13 RULE_14 RULE_15

    // Register loads: the datapath wins, the bus only lands while idle
    assign exec_acc     = exec & to_acc;
    assign exec_mem     = exec & to_mem;
    assign wr_acc       = idle_write(wr_fire, hit_acc, idle);
    assign wr_mem       = idle_write(wr_fire, hit_mem, idle);
    assign wr_imm       = idle_write(wr_fire, hit_imm, idle);
    assign wr_flags     = idle_write(wr_fire, hit_flags, idle);
    assign wr_byte      = pwdata[rsk_pkg::BYTE_W-1:0];
    assign wr_flags_val = wr_byte[$bits(rsk_pkg::rsk_flags_t)-1:0];
    assign busy         = ~idle;

    // Accumulator: result only for accumulator forms, bus load while idle
    assign acc_next = exec_acc ? result : // RULE_02 RULE_04 RULE_06 RULE_10 RULE_14
                      wr_acc ? wr_byte : acc_reg;

    // Memory byte: written back only by memory forms
    assign mem_next = exec_mem ? result : // RULE_01 RULE_03 RULE_05 RULE_11 RULE_12
                      wr_mem ? wr_byte : mem_reg; // RULE_19

    assign imm_next = wr_imm ? wr_byte : imm_reg;

    // Flags: subtracts load all four, carry rotates load carry, others hold
    always_comb begin
        flags_next = flags_reg; // RULE_20
        if (exec & is_arith) begin
            flags_next = arith.flags; // RULE_07 RULE_08 RULE_16 RULE_17 RULE_18
        end else if (exec & is_rot_carry) begin
            flags_next.carry_flag = bit_cout; // RULE_01 RULE_02 RULE_05 RULE_06
        end else if (wr_flags) begin
            flags_next = wr_flags_val;
        end
    end

    // Sequence: execute, then one dummy cycle when the next fetch is dropped
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            rsk_pkg::ST_IDLE: begin
                if (launch) begin
                    state_next = rsk_pkg::ST_EXEC;
                end
            end
            rsk_pkg::ST_EXEC: begin
                state_next = skip_now ? rsk_pkg::ST_DUMMY : rsk_pkg::ST_IDLE; // RULE_15
            end
            rsk_pkg::ST_DUMMY: begin
                state_next = rsk_pkg::ST_IDLE; // RULE_20
            end
            default: begin
                state_next = rsk_pkg::ST_IDLE;
            end
        endcase
    end

    // Status bookkeeping; a new error beats a clear in the same cycle
    assign skip_next = exec ? skip_now : skip_reg;
    assign err_next  = bad_launch | (err_reg & ~err_clear);
    assign cnt_next  = exec ? cnt_reg + 8'h01 : cnt_reg;

    // Read mux
    always_comb begin
        rd_data = '0;
        if (hit_cmd) begin
            rd_data[rsk_pkg::CMD_OP_LSB +: rsk_pkg::CMD_OP_W]   = cmd_reg.op;
            rd_data[rsk_pkg::CMD_BIT_LSB +: rsk_pkg::CMD_BIT_W] = cmd_reg.bit_sel;
        end else if (hit_acc) begin
            rd_data[7:0] = acc_reg;
        end else if (hit_mem) begin
            rd_data[7:0] = mem_reg;
        end else if (hit_imm) begin
            rd_data[7:0] = imm_reg;
        end else if (hit_flags) begin
            rd_data[3:0] = flags_reg;
        end else if (hit_status) begin
            rd_data[rsk_pkg::ST_BUSY_BIT] = busy;
            rd_data[rsk_pkg::ST_SKIP_BIT] = skip_reg;
            rd_data[rsk_pkg::ST_ERR_BIT]  = err_reg;
            rd_data[rsk_pkg::ST_CNT_LSB +: rsk_pkg::ST_CNT_W] = cnt_reg;
        end
    end

    // Bus answer: one wait state on every access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= first_access;
            pslverr_reg <= first_access & ~mapped;
            prdata_reg  <= (first_access & ~pwrite) ? rd_data : '0;
        end
    end

    // Datapath state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg   <= rsk_pkg::ACC_RST;
            mem_reg   <= rsk_pkg::MEM_RST;
            imm_reg   <= rsk_pkg::IMM_RST;
            flags_reg <= rsk_pkg::FLAGS_RST;
        end else begin
            acc_reg   <= acc_next;
            mem_reg   <= mem_next;
            imm_reg   <= imm_next;
            flags_reg <= flags_next;
        end
    end

    // Control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= rsk_pkg::ST_IDLE;
            cmd_reg     <= '0;
            skip_reg    <= 1'b0;
            err_reg     <= 1'b0;
            cnt_reg     <= '0;
            discard_reg <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cmd_reg     <= cmd_next;
            skip_reg    <= skip_next;
            err_reg     <= err_next;
            cnt_reg     <= cnt_next;
            discard_reg <= skip_now; // RULE_09 RULE_13
            done_reg    <= (exec & ~skip_now) | dummy;
        end
    end

    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign prdata        = prdata_reg;
    assign fetch_discard = discard_reg;
    assign op_done       = done_reg;
endmodule

// file: testbench/rsk_datapath_checker.sv
`timescale 1ns/1ps
module rsk_datapath_checker (
    // Clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // APB slave
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [rsk_pkg::ADDR_W-1:0] paddr,
    input wire logic [rsk_pkg::DATA_W-1:0] pwdata,
    input wire logic [rsk_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // Sequencer side
    input wire logic                       fetch_discard,
    input wire logic                       op_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire go_wr = psel && penable && pready && pwrite && (paddr == rsk_pkg::OFF_CMD) && pwdata[31];
    wire mapped = paddr inside {rsk_pkg::OFF_CMD, rsk_pkg::OFF_ACC, rsk_pkg::OFF_MEM,
                                rsk_pkg::OFF_IMM, rsk_pkg::OFF_FLAGS, rsk_pkg::OFF_STATUS};

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    ready_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_phase_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside second access cycle");
    err_unmapped_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access without pslverr");
    err_mapped_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access with pslverr");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside read answer");
    skip_done_a: assert property (fetch_discard |=> op_done && !fetch_discard)
        else $error("dummy cycle not followed by done");
    discard_time_a: assert property (fetch_discard |-> $past(go_wr, 2))
        else $error("dummy cycle at wrong time");
    done_time_a: assert property (op_done |-> $past(go_wr, 2) || $past(go_wr, 3))
        else $error("done at wrong time");
endmodule

bind rsk_datapath rsk_datapath_checker i_rsk_datapath_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_discard(fetch_discard), .op_done(op_done));

// file: testbench/rsk_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rsk_datapath_tb;
    logic                       pclk, presetn, psel, penable, pwrite;
    logic [rsk_pkg::ADDR_W-1:0] paddr;
    logic [rsk_pkg::DATA_W-1:0] pwdata, prdata, rd;
    logic                       pready, pslverr, fetch_discard, op_done, er, es;
    logic [7:0]                 ea, em;
    logic [3:0]                 ef;
    int                         num_errors = 0, checks = 0, cyc = 0;

    rsk_datapath i_rsk_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fetch_discard(fetch_discard), .op_done(op_done));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task final_report;
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report;
        end
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask

    // Reference result of one operation
    task model(input logic [4:0] op, input logic [7:0] a, m, x, input logic [3:0] f,
               input logic [2:0] b);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] y;
        logic       ci;
        ea = a; em = m; ef = f; es = 1'b0;
        y = (op == 5'h12) ? x : m;
        ci = (op == 5'h07 || op == 5'h08) ? f[0] : 1'b1;
        s = {1'b0, a} + {1'b0, ~y} + {8'h0, ci};
        h = {1'b0, a[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
        case (op)
            5'h01: begin em = {m[6:0], f[0]}; ef[0] = m[7]; end
            5'h02: begin ea = {m[6:0], f[0]}; ef[0] = m[7]; end
            5'h03: em = {m[0], m[7:1]};
            5'h04: ea = {m[0], m[7:1]};
            5'h05: begin em = {f[0], m[7:1]}; ef[0] = m[0]; end
            5'h06: begin ea = {f[0], m[7:1]}; ef[0] = m[0]; end
            5'h09: begin em = m - 8'h01; es = (em == 8'h00); end
            5'h0a: begin ea = m - 8'h01; es = (ea == 8'h00); end
            5'h0b: em = 8'hff;
            5'h0c: em[b] = 1'b1;
            5'h0d: begin em = m + 8'h01; es = (em == 8'h00); end
            5'h0e: begin ea = m + 8'h01; es = (ea == 8'h00); end
            5'h0f: es = m[b];
            5'h13: em = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (op == 5'h07 || op == 5'h08 || op == 5'h10 || op == 5'h11 || op == 5'h12) begin
            if (op == 5'h08 || op == 5'h11) em = s[7:0];
            else ea = s[7:0];
            ef = {(a[7] == ~y[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
        end
    endtask

    task run_op(input logic [4:0] op, input int k);
        logic [7:0] a, m, x;
        logic [3:0] f;
        logic [2:0] b;
        int         n;
        logic       d;
        m = (k == 0) ? 8'h01 : (k == 1) ? 8'hff : 8'h96;
        a = (k == 0) ? 8'h01 : (k == 1) ? 8'h7f : 8'h80;
        x = (k == 0) ? 8'h01 : 8'h3c;
        f = (k == 1) ? 4'ha : 4'h5;
        b = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'h3;
        model(op, a, m, x, f, b);
        apb(1'b1, rsk_pkg::OFF_ACC, {24'h0, a});
        apb(1'b1, rsk_pkg::OFF_MEM, {24'h0, m});
        apb(1'b1, rsk_pkg::OFF_IMM, {24'h0, x});
        apb(1'b1, rsk_pkg::OFF_FLAGS, {28'h0, f});
        apb(1'b1, rsk_pkg::OFF_CMD, {1'b1, 20'h0, b, 3'h0, op});
        n = 0;
        d = 1'b0;
        do begin @(posedge pclk); n++; d |= fetch_discard; end while (op_done !== 1'b1 && n < 10);
        `CHK(n, es ? 3 : 2)
        `CHK(d, es)
        rdc(rsk_pkg::OFF_ACC, {24'h0, ea});
        rdc(rsk_pkg::OFF_MEM, {24'h0, em});
        rdc(rsk_pkg::OFF_FLAGS, {28'h0, ef});
        apb(1'b0, rsk_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[1:0], {es, 1'b0})
        $display("test op %h set %0d done", op, k);
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(rsk_pkg::OFF_ACC, 32'h0);
        rdc(rsk_pkg::OFF_MEM, 32'h0);
        rdc(rsk_pkg::OFF_FLAGS, 32'h0);
        rdc(12'h018, 32'h0);
        `CHK(er, 1'b1)
        $display("test reset and map done");
        for (int k = 0; k < 3; k++) begin
            for (int op = 1; op <= 19; op++) begin
                run_op(op[4:0], k);
            end
        end
        apb(1'b0, rsk_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[15:8], 8'h39)
        apb(1'b1, rsk_pkg::OFF_CMD, 32'h8000_0000);
        apb(1'b0, rsk_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[2], 1'b1)
        apb(1'b1, rsk_pkg::OFF_STATUS, 32'h4);
        apb(1'b0, rsk_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[2], 1'b0)
        $display("test status done");
        final_report;
    end
endmodule
